// ---- rtl/ocm_cfg_pkg.sv ----
// Constants shared by the on-chip memory configuration and fill block
package ocm_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices on the control register port
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_INSTR_RANGE = 4'h0;
  localparam logic [3:0] IDX_INSTR_CTRL = 4'h1;
  localparam logic [3:0] IDX_INIT_ADDR = 4'h2;
  localparam logic [3:0] IDX_FILL_DATA = 4'h3;
  localparam logic [3:0] IDX_DATA_RANGE = 4'h4;
  localparam logic [3:0] IDX_DATA_CTRL = 4'h5;

  // ----------------------------------------------------------------
  // Control register fields, bit 7 is the leftmost (first) bit
  // ----------------------------------------------------------------
  localparam int CTL_EN_POS = 7;
  localparam int CTL_FWD_OFF_POS = 6;
  localparam int CTL_READBACK_POS = 5;
  localparam int CTL_AUTO_POS = 4;
  localparam int CTL_WAIT_LSB = 0;
  localparam int CTL_WAIT_W = 4;
  // Writable bits; the rest are reserved and read as zero
  localparam logic [7:0] INSTR_CTL_MASK = 8'hBF;
  localparam logic [7:0] DATA_CTL_MASK = 8'hDF;
  // Control byte sits in the low byte of the 32-bit register word
  localparam int CTL_DATA_LSB = 0;

  // ----------------------------------------------------------------
  // Initialisation address mapping
  // ----------------------------------------------------------------
  localparam int INIT_W = 22;
  localparam int MEM_ADDR_W = 21;
  // Word bits 8..29 counted from the left are bits 23..2
  localparam int INIT_WR_LSB = 2;
  // Legacy readback places them in word bits 0..21, i.e. bits 31..10
  localparam int INIT_LEGACY_LSB = 10;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RANGE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [21:0] INIT_RESET = 22'h00_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0] WAIT_1TO1 = 4'h1;
  localparam logic [3:0] MAX_RATIO = 4'h8;
  // Processor cycles from readback enable to data sampled
  localparam int READBACK_WAIT = 2;

  // Readback sequencer
  typedef enum logic [2:0] {
    RB_IDLE = 3'b001,
    RB_ADDR = 3'b010,
    RB_DATA = 3'b100
  } rb_state_t;

endpackage

// ---- rtl/range_decoder.sv ----
// Address range decoder for one memory controller
`timescale 1ns/10ps
`default_nettype none
module range_decoder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic [7:0] range_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  output logic hit_o
);

  // Top byte selects a 16 MB region; a cleared enable blocks every hit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= req_i && enable_i && (addr_i[31:24] == range_i);
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ratio_detect.sv ----
// Measures processor clocks per memory clock and reports it as 2n-1
`timescale 1ns/10ps
`default_nettype none
module ratio_detect (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mem_clk_i,
  output logic [3:0] code_o
);

  logic prev_ff;
  logic [3:0] cnt_ff;
  logic [4:0] twice;

  assign twice = {cnt_ff, 1'b0} - 5'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 1'b0;
      cnt_ff <= 4'h0;
      code_o <= ocm_cfg_pkg::WAIT_1TO1;
    end else begin
      prev_ff <= mem_clk_i;
      if (mem_clk_i && !prev_ff) begin
        cnt_ff <= 4'h1;
        if (cnt_ff != 4'h0) begin
          code_o <= twice[3:0];
        end
      end else if (cnt_ff != 4'h0 && cnt_ff < ocm_cfg_pkg::MAX_RATIO) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ocm_dcr_config_and_fill.sv ----
// Register bank, address decode and indirect fill path of the memory controllers
`timescale 1ns/10ps
`default_nettype none
module ocm_dcr_config_and_fill (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] range_preset_input_i,
  input wire logic [7:0] control_preset_input_i,
  input wire logic [7:0] data_range_preset_i,
  input wire logic [7:0] data_control_preset_i,
  input wire logic [3:0] regbus_addr_i,
  input wire logic regbus_wr_i,
  input wire logic regbus_rd_i,
  input wire logic [31:0] regbus_data_i,
  output logic [31:0] regbus_data_o,
  output logic regbus_ack_o,
  input wire logic instr_mem_clock_i,
  input wire logic data_mem_clock_i,
  input wire logic instr_req_i,
  input wire logic [31:0] instr_addr_i,
  output logic instr_hit_o,
  input wire logic data_req_i,
  input wire logic [31:0] data_addr_i,
  output logic data_hit_o,
  input wire logic load_valid_i,
  input wire logic [31:0] load_data_i,
  output logic operand_valid_o,
  output logic [31:0] operand_data_o,
  output logic [3:0] instr_side_wait_ratio_o,
  output logic [3:0] data_side_wait_ratio_o,
  output logic [20:0] mem_write_addr_bus_o,
  output logic [31:0] mem_write_data_bus_o,
  output logic odd_bank_write_en_o,
  output logic even_bank_write_en_o,
  output logic odd_bank_regpath_en_o,
  output logic even_bank_regpath_en_o,
  input wire logic [31:0] mem_readback_bus_i
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic preset_pending_ff;
  logic [7:0] instr_range_compare_ff;
  logic [7:0] instr_mem_control_ff;
  logic [7:0] data_range_ff;
  logic [7:0] data_ctrl_ff;
  logic [21:0] instr_init_address_ff;
  logic [31:0] instr_fill_data_ff;
  logic [3:0] instr_detect;
  logic [3:0] data_detect;
  logic [3:0] nxt_instr_wait;
  logic [3:0] nxt_data_wait;
  logic [7:0] instr_ctl_view;
  logic [7:0] data_ctl_view;
  logic [31:0] nxt_rd_data;
  logic wr_init;
  logic wr_fill;
  logic rd_fill_mem;
  logic readback_on;
  logic fwd_off;
  ocm_cfg_pkg::rb_state_t rb_state_ff;
  ocm_cfg_pkg::rb_state_t nxt_rb_state;
  logic [31:0] steer_ff;
  logic steer_valid_ff;

  assign readback_on = instr_mem_control_ff[ocm_cfg_pkg::CTL_READBACK_POS];
  assign fwd_off = data_ctrl_ff[ocm_cfg_pkg::CTL_FWD_OFF_POS];
  assign wr_init = regbus_wr_i && (regbus_addr_i == ocm_cfg_pkg::IDX_INIT_ADDR);
  assign wr_fill = regbus_wr_i && (regbus_addr_i == ocm_cfg_pkg::IDX_FILL_DATA);
  assign rd_fill_mem = regbus_rd_i && readback_on && (rb_state_ff == ocm_cfg_pkg::RB_IDLE)
                       && (regbus_addr_i == ocm_cfg_pkg::IDX_FILL_DATA);

  // ----------------------------------------------------------------
  // Range and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      preset_pending_ff <= 1'b1;
      instr_range_compare_ff <= ocm_cfg_pkg::RANGE_RESET;
      instr_mem_control_ff <= ocm_cfg_pkg::CTRL_RESET;
      data_range_ff <= ocm_cfg_pkg::RANGE_RESET;
      data_ctrl_ff <= ocm_cfg_pkg::CTRL_RESET;
    end else if (preset_pending_ff) begin
      // First cycle after release takes the fabric preset vectors
      preset_pending_ff <= 1'b0;
      instr_range_compare_ff <= range_preset_input_i;
      instr_mem_control_ff <= control_preset_input_i & ocm_cfg_pkg::INSTR_CTL_MASK;
      data_range_ff <= data_range_preset_i;
      data_ctrl_ff <= data_control_preset_i & ocm_cfg_pkg::DATA_CTL_MASK;
    end else if (regbus_wr_i) begin
      if (regbus_addr_i == ocm_cfg_pkg::IDX_INSTR_RANGE) begin
        instr_range_compare_ff <= regbus_data_i[ocm_cfg_pkg::CTL_DATA_LSB +: 8];
      end else if (regbus_addr_i == ocm_cfg_pkg::IDX_INSTR_CTRL) begin
        instr_mem_control_ff <= regbus_data_i[ocm_cfg_pkg::CTL_DATA_LSB +: 8]
                                & ocm_cfg_pkg::INSTR_CTL_MASK;
      end else if (regbus_addr_i == ocm_cfg_pkg::IDX_DATA_RANGE) begin
        data_range_ff <= regbus_data_i[ocm_cfg_pkg::CTL_DATA_LSB +: 8];
      end else if (regbus_addr_i == ocm_cfg_pkg::IDX_DATA_CTRL) begin
        data_ctrl_ff <= regbus_data_i[ocm_cfg_pkg::CTL_DATA_LSB +: 8]
                        & ocm_cfg_pkg::DATA_CTL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  range_decoder u_instr_dec (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .enable_i(instr_mem_control_ff[ocm_cfg_pkg::CTL_EN_POS]),
    .range_i(instr_range_compare_ff),
    .req_i(instr_req_i),
    .addr_i(instr_addr_i),
    .hit_o(instr_hit_o)
  );

  range_decoder u_data_dec (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .enable_i(data_ctrl_ff[ocm_cfg_pkg::CTL_EN_POS]),
    .range_i(data_range_ff),
    .req_i(data_req_i),
    .addr_i(data_addr_i),
    .hit_o(data_hit_o)
  );

  // ----------------------------------------------------------------
  // Clock ratio
  // ----------------------------------------------------------------
  ratio_detect u_instr_ratio (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .mem_clk_i(instr_mem_clock_i),
    .code_o(instr_detect)
  );

  ratio_detect u_data_ratio (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .mem_clk_i(data_mem_clock_i),
    .code_o(data_detect)
  );

  // Even codes are unsupported and are run as the odd code just above
  always_comb begin
    nxt_instr_wait = instr_mem_control_ff[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W]
                     | 4'h1;
    nxt_data_wait = data_ctrl_ff[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W]
                    | 4'h1;
    if (instr_mem_control_ff[ocm_cfg_pkg::CTL_AUTO_POS]) begin
      nxt_instr_wait = instr_detect;
    end
    if (data_ctrl_ff[ocm_cfg_pkg::CTL_AUTO_POS]) begin
      nxt_data_wait = data_detect;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      instr_side_wait_ratio_o <= ocm_cfg_pkg::WAIT_1TO1;
      data_side_wait_ratio_o <= ocm_cfg_pkg::WAIT_1TO1;
    end else begin
      instr_side_wait_ratio_o <= nxt_instr_wait;
      data_side_wait_ratio_o <= nxt_data_wait;
    end
  end

  // ----------------------------------------------------------------
  // Load data path
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      steer_ff <= ocm_cfg_pkg::WORD_RESET;
      steer_valid_ff <= 1'b0;
      operand_data_o <= ocm_cfg_pkg::WORD_RESET;
      operand_valid_o <= 1'b0;
    end else begin
      steer_ff <= load_data_i;
      steer_valid_ff <= load_valid_i;
      if (fwd_off) begin
        // Extra latch stage adds the second cycle of latency
        operand_data_o <= steer_ff;
        operand_valid_o <= steer_valid_ff;
      end else begin
        operand_data_o <= load_data_i;
        operand_valid_o <= load_valid_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Initialisation address and fill data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      instr_init_address_ff <= ocm_cfg_pkg::INIT_RESET;
    end else if (wr_init) begin
      instr_init_address_ff <= regbus_data_i[ocm_cfg_pkg::INIT_WR_LSB +: ocm_cfg_pkg::INIT_W];
    end else if (wr_fill) begin
      instr_init_address_ff <= instr_init_address_ff + 22'h00_0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      instr_fill_data_ff <= ocm_cfg_pkg::WORD_RESET;
    end else if (wr_fill) begin
      instr_fill_data_ff <= regbus_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Memory write and register-path enables
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mem_write_addr_bus_o <= 21'h00_0000;
      mem_write_data_bus_o <= ocm_cfg_pkg::WORD_RESET;
      odd_bank_write_en_o <= 1'b0;
      even_bank_write_en_o <= 1'b0;
    end else begin
      mem_write_addr_bus_o <= instr_init_address_ff[ocm_cfg_pkg::INIT_W-1:1];
      if (wr_fill) begin
        mem_write_data_bus_o <= regbus_data_i;
      end
      // One write pulse per fill; bank follows the address low bit
      odd_bank_write_en_o <= wr_fill && instr_init_address_ff[0];
      even_bank_write_en_o <= wr_fill && !instr_init_address_ff[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      odd_bank_regpath_en_o <= 1'b0;
      even_bank_regpath_en_o <= 1'b0;
    end else begin
      odd_bank_regpath_en_o <= (wr_fill || rd_fill_mem) && instr_init_address_ff[0];
      even_bank_regpath_en_o <= (wr_fill || rd_fill_mem) && !instr_init_address_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // Memory readback sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rb_state = rb_state_ff;
    case (rb_state_ff)
      ocm_cfg_pkg::RB_IDLE: begin
        if (rd_fill_mem) begin
          nxt_rb_state = ocm_cfg_pkg::RB_ADDR;
        end
      end
      ocm_cfg_pkg::RB_ADDR: begin
        nxt_rb_state = ocm_cfg_pkg::RB_DATA;
      end
      ocm_cfg_pkg::RB_DATA: begin
        nxt_rb_state = ocm_cfg_pkg::RB_IDLE;
      end
      default: begin
        nxt_rb_state = ocm_cfg_pkg::RB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rb_state_ff <= ocm_cfg_pkg::RB_IDLE;
    end else begin
      rb_state_ff <= nxt_rb_state;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    instr_ctl_view = instr_mem_control_ff & ocm_cfg_pkg::INSTR_CTL_MASK;
    data_ctl_view = data_ctrl_ff & ocm_cfg_pkg::DATA_CTL_MASK;
    instr_ctl_view[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W] =
      instr_mem_control_ff[ocm_cfg_pkg::CTL_AUTO_POS] ? instr_detect
      : instr_mem_control_ff[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W];
    data_ctl_view[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W] =
      data_ctrl_ff[ocm_cfg_pkg::CTL_AUTO_POS] ? data_detect
      : data_ctrl_ff[ocm_cfg_pkg::CTL_WAIT_LSB +: ocm_cfg_pkg::CTL_WAIT_W];
    nxt_rd_data = ocm_cfg_pkg::WORD_RESET;
    if (regbus_addr_i == ocm_cfg_pkg::IDX_INSTR_RANGE) begin
      nxt_rd_data[ocm_cfg_pkg::CTL_DATA_LSB +: 8] = instr_range_compare_ff;
    end else if (regbus_addr_i == ocm_cfg_pkg::IDX_INSTR_CTRL) begin
      nxt_rd_data[ocm_cfg_pkg::CTL_DATA_LSB +: 8] = instr_ctl_view;
    end else if (regbus_addr_i == ocm_cfg_pkg::IDX_INIT_ADDR) begin
      if (readback_on) begin
        nxt_rd_data[ocm_cfg_pkg::INIT_WR_LSB +: ocm_cfg_pkg::INIT_W] =
          instr_init_address_ff;
      end else begin
        nxt_rd_data[ocm_cfg_pkg::INIT_LEGACY_LSB +: ocm_cfg_pkg::INIT_W] =
          instr_init_address_ff;
      end
    end else if (regbus_addr_i == ocm_cfg_pkg::IDX_FILL_DATA) begin
      nxt_rd_data = instr_fill_data_ff;
    end else if (regbus_addr_i == ocm_cfg_pkg::IDX_DATA_RANGE) begin
      nxt_rd_data[ocm_cfg_pkg::CTL_DATA_LSB +: 8] = data_range_ff;
    end else if (regbus_addr_i == ocm_cfg_pkg::IDX_DATA_CTRL) begin
      nxt_rd_data[ocm_cfg_pkg::CTL_DATA_LSB +: 8] = data_ctl_view;
    end
  end

  // Plain accesses answer next cycle; memory readback answers after the fetch
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      regbus_data_o <= ocm_cfg_pkg::WORD_RESET;
      regbus_ack_o <= 1'b0;
    end else if (rb_state_ff == ocm_cfg_pkg::RB_DATA) begin
      regbus_data_o <= mem_readback_bus_i;
      regbus_ack_o <= 1'b1;
    end else if (rb_state_ff == ocm_cfg_pkg::RB_IDLE && regbus_rd_i && !rd_fill_mem) begin
      regbus_data_o <= nxt_rd_data;
      regbus_ack_o <= 1'b1;
    end else if (rb_state_ff == ocm_cfg_pkg::RB_IDLE && regbus_wr_i) begin
      regbus_ack_o <= 1'b1;
    end else begin
      regbus_ack_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- bench/bram_model.sv ----
// Behavioural block RAM behind the fill and readback path
`timescale 1ns/10ps
`default_nettype none
module bram_model (
  input wire logic clk_i,
  input wire logic [20:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic odd_we_i,
  input wire logic even_we_i,
  input wire logic odd_en_i,
  input wire logic even_en_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [21:0]];
  initial rdata_o = 32'h0000_0000;
  // ------------------------------------------------------------
  // Storage; read data stands one cycle, then keeps changing
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (odd_we_i || even_we_i) begin
      mem[{addr_i, odd_we_i}] = wdata_i;
      rdata_o <= ~rdata_o;
    end else if ((odd_en_i || even_en_i) && mem.exists({addr_i, odd_en_i})) begin
      rdata_o <= mem[{addr_i, odd_en_i}];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ---- bench/ocm_cfg_checker_asserts.sv ----
// Port-level checks of the configuration and fill block
`timescale 1ns/10ps
`default_nettype none
module ocm_cfg_checker (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] regbus_addr_i,
  input wire logic regbus_wr_i,
  input wire logic regbus_rd_i,
  input wire logic [31:0] regbus_data_i,
  input wire logic [31:0] regbus_data_o,
  input wire logic regbus_ack_o,
  input wire logic instr_req_i,
  input wire logic instr_hit_o,
  input wire logic data_req_i,
  input wire logic data_hit_o,
  input wire logic load_valid_i,
  input wire logic [31:0] load_data_i,
  input wire logic operand_valid_o,
  input wire logic [31:0] operand_data_o,
  input wire logic [3:0] instr_side_wait_ratio_o,
  input wire logic [3:0] data_side_wait_ratio_o,
  input wire logic [20:0] mem_write_addr_bus_o,
  input wire logic [31:0] mem_write_data_bus_o,
  input wire logic odd_bank_write_en_o,
  input wire logic even_bank_write_en_o,
  input wire logic odd_bank_regpath_en_o,
  input wire logic even_bank_regpath_en_o,
  input wire logic [31:0] mem_readback_bus_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic we;
  assign we = odd_bank_write_en_o || even_bank_write_en_o;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_wait_odd: assert property (instr_side_wait_ratio_o[0] && data_side_wait_ratio_o[0])
    else $error("wait code is even");
  a_ihit_cause: assert property (instr_hit_o |-> $past(instr_req_i))
    else $error("instr hit without request");
  a_dhit_cause: assert property (data_hit_o |-> $past(data_req_i))
    else $error("data hit without request");
  a_load_lat: assert property (operand_valid_o |->
    ($past(load_valid_i) && operand_data_o == $past(load_data_i)) ||
    ($past(load_valid_i, 2) && operand_data_o == $past(load_data_i, 2)))
    else $error("operand not from a load one or two cycles back");
  a_one_bank: assert property (!(odd_bank_write_en_o && even_bank_write_en_o))
    else $error("both banks written");
  a_write_cause: assert property (we |-> $past(regbus_wr_i) &&
    $past(regbus_addr_i) == ocm_cfg_pkg::IDX_FILL_DATA &&
    mem_write_data_bus_o == $past(regbus_data_i))
    else $error("memory write without matching fill write");
  a_addr_carry: assert property (odd_bank_write_en_o |=>
    mem_write_addr_bus_o == $past(mem_write_addr_bus_o) + 21'h00_0001)
    else $error("word address not advanced after odd write");
  a_addr_hold: assert property (even_bank_write_en_o |=> $stable(mem_write_addr_bus_o))
    else $error("word address moved after even write");
  a_regpath_bank: assert property (we |-> odd_bank_regpath_en_o == odd_bank_write_en_o &&
    even_bank_regpath_en_o == even_bank_write_en_o)
    else $error("bank enable differs from write bank");
  a_readback_ack: assert property ((odd_bank_regpath_en_o || even_bank_regpath_en_o) && !we
    |-> ##2 regbus_ack_o && regbus_data_o == $past(mem_readback_bus_i))
    else $error("readback word not returned");
  a_ctl_reserved: assert property (regbus_rd_i && regbus_addr_i == ocm_cfg_pkg::IDX_INSTR_CTRL
    |=> regbus_ack_o && regbus_data_o[31:8] == 24'h00_0000 && !regbus_data_o[6])
    else $error("reserved control bits read nonzero");
endmodule
bind ocm_dcr_config_and_fill ocm_cfg_checker i_ocm_cfg_checker (.ref_clk_i, .resetn_i,
  .regbus_addr_i, .regbus_wr_i, .regbus_rd_i, .regbus_data_i, .regbus_data_o, .regbus_ack_o,
  .instr_req_i, .instr_hit_o, .data_req_i, .data_hit_o, .load_valid_i, .load_data_i,
  .operand_valid_o, .operand_data_o, .instr_side_wait_ratio_o, .data_side_wait_ratio_o,
  .mem_write_addr_bus_o, .mem_write_data_bus_o, .odd_bank_write_en_o, .even_bank_write_en_o,
  .odd_bank_regpath_en_o, .even_bank_regpath_en_o, .mem_readback_bus_i);
`default_nettype wire

// ---- bench/ocm_dcr_config_and_fill_bench.sv ----
// Self-checking bench for the configuration and fill block
`timescale 1ns/10ps
`default_nettype none
module ocm_dcr_config_and_fill_bench;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, ireq = 0, dreq = 0, lv = 0, imc = 0, dmc = 0;
  logic [7:0] rp = 0, cp = 0, drp = 0, dcp = 0, r;
  logic [3:0] ra = 0, iw, dw;
  logic [31:0] wd = 0, ia = 0, da = 0, ld = 0, rdt, mrb, od, mwd, got, s_wd;
  logic [20:0] wab, s_wa;
  logic ack, ih, dh, ov, oe, ee, orp, erp, s_oe, s_ee;
  logic [1:0] s_rp;
  int mismatches = 0, samples_checked = 0, cyc = 0, ic = 0;
  int bm [int];
  ocm_dcr_config_and_fill i_ocm_dcr_config_and_fill (.ref_clk_i(clk), .resetn_i(rstn),
    .range_preset_input_i(rp), .control_preset_input_i(cp), .data_range_preset_i(drp),
    .data_control_preset_i(dcp), .regbus_addr_i(ra), .regbus_wr_i(wr), .regbus_rd_i(rd),
    .regbus_data_i(wd), .regbus_data_o(rdt), .regbus_ack_o(ack), .instr_mem_clock_i(imc),
    .data_mem_clock_i(dmc), .instr_req_i(ireq), .instr_addr_i(ia), .instr_hit_o(ih),
    .data_req_i(dreq), .data_addr_i(da), .data_hit_o(dh), .load_valid_i(lv),
    .load_data_i(ld), .operand_valid_o(ov), .operand_data_o(od),
    .instr_side_wait_ratio_o(iw), .data_side_wait_ratio_o(dw), .mem_write_addr_bus_o(wab),
    .mem_write_data_bus_o(mwd), .odd_bank_write_en_o(oe), .even_bank_write_en_o(ee),
    .odd_bank_regpath_en_o(orp), .even_bank_regpath_en_o(erp), .mem_readback_bus_i(mrb));
  bram_model i_bram_model (.clk_i(clk), .addr_i(wab), .wdata_i(mwd), .odd_we_i(oe),
    .even_we_i(ee), .odd_en_i(orp), .even_en_i(erp), .rdata_o(mrb));
  // ------------------------------------------------------------
  // Clocks: memory clocks at 3:1 (instr) and 2:1 (data)
  // ------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ic <= (ic == 2) ? 0 : ic + 1;
    imc <= (ic == 0);
    dmc <= ~dmc;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Register access; snapshots the memory write port at the answer
  task automatic acc(input logic [3:0] idx, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    ra <= idx;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (ack !== 1'b1 && k < 8);
    if (k == 8) check(32'h0000_0000, 32'h0000_0001);
    got = rdt;
    s_oe = oe;
    s_ee = ee;
    s_rp = {orp, erp};
    s_wa = wab;
    s_wd = mwd;
  endtask
  initial begin
    int n, k, a;
    n = $urandom(17474);
    @(posedge clk);
    rp <= 8'($urandom);
    cp <= 8'($urandom) & 8'hEF;
    drp <= 8'($urandom);
    dcp <= 8'($urandom) & 8'hEF;
    repeat (19) @(posedge clk);
    rstn <= 1;
    repeat (4) @(posedge clk);
    acc(4'h0, 0, 0);
    check(got, 32'(rp));
    acc(4'h1, 0, 0);
    check(got, 32'(cp & 8'hBF));
    acc(4'h4, 0, 0);
    check(got, 32'(drp));
    acc(4'h5, 0, 0);
    check(got, 32'(dcp & 8'hDF));
    check(32'(iw), 32'(cp[3:0] | 4'h1));
    for (int i = 0; i < 6; i++) begin
      n = $urandom & 32'h0000_00EF;
      acc(4'h1, 1, n);
      acc(4'h1, 0, 0);
      check(got, n & 32'h0000_00BF);
      acc(4'h5, 1, n);
      acc(4'h5, 0, 0);
      check(got, n & 32'h0000_00DF);
      check(32'(iw), 32'(n[3:0] | 4'h1));
      check(32'(dw), 32'(n[3:0] | 4'h1));
    end
    acc(4'h1, 1, 32'h0000_0090);
    acc(4'h5, 1, 32'h0000_0090);
    repeat (20) @(posedge clk);
    acc(4'h1, 0, 0);
    check(got, 32'h0000_0095);
    check(32'(dw), 32'h0000_0003);
    check(32'(iw), 32'h0000_0005);
    r = 8'($urandom);
    acc(4'h0, 1, 32'(r));
    acc(4'h4, 1, 32'(r));
    for (int i = 0; i < 4; i++) begin
      n = $urandom;
      acc(4'h1, 1, i > 1 ? 32'h0000_0080 : 32'h0000_0000);
      acc(4'h5, 1, 32'({i > 1, i[0], 6'h01}));
      @(posedge clk);
      ireq <= 1;
      dreq <= 1;
      lv <= 1;
      ld <= n;
      ia <= {i[0] ? r : ~r, n[23:0]};
      da <= {i[0] ? r : ~r, n[31:8]};
      @(posedge clk);
      ireq <= 0;
      dreq <= 0;
      lv <= 0;
      k = 1;
      @(negedge clk);
      check(32'(ih), 32'(i == 3));
      check(32'(dh), 32'(i == 3));
      while (ov !== 1'b1 && k < 4) begin
        @(negedge clk);
        k++;
      end
      check(32'(k), i[0] ? 32'h0000_0002 : 32'h0000_0001);
      check(od, n);
    end
    a = $urandom & 32'h003F_FFF1;
    acc(4'h1, 1, 32'h0000_0080);
    acc(4'h2, 1, 32'(a) << 2);
    acc(4'h2, 0, 0);
    check(got, 32'(a) << 10);
    acc(4'h1, 1, 32'h0000_00A0);
    acc(4'h2, 0, 0);
    check(got, 32'(a) << 2);
    for (int i = 0; i < 5; i++) begin
      n = $urandom;
      bm[a + i] = n;
      acc(4'h3, 1, n);
      check(32'(s_oe), 32'((a + i) % 2));
      check(32'(s_ee), 32'(1 - (a + i) % 2));
      check(32'(s_rp), ((a + i) % 2) ? 32'h0000_0002 : 32'h0000_0001);
      check(32'(s_wa), 32'((a + i) >> 1));
      check(s_wd, n);
    end
    acc(4'h2, 0, 0);
    check(got, 32'(a + 5) << 2);
    for (int i = 0; i < 5; i++) begin
      acc(4'h2, 1, 32'(a + i) << 2);
      acc(4'h3, 0, 0);
      check(got, bm[a + i]);
    end
    acc(4'h1, 1, 32'h0000_0080);
    acc(4'h3, 0, 0);
    check(got, bm[a + 4]);
    acc(4'hF, 0, 0);
    check(got, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
